// ---- rtl/csp_pkg.sv ----
/*
 * Package for the clock source and PLL configuration block: register
 * offsets, field positions, reset values, selection codes and wait counts.
 * Assumes a 32-bit AHB-Lite register bus on a single clock.
 */
package csp_pkg;
    localparam logic [7:0] OFS_PLL_CTRL = 8'h00;
    localparam logic [7:0] OFS_PLL_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_SECOND_PHASE_LOCKED_LOOP_CTRL = 8'h08;
    localparam logic [7:0] OFS_SECOND_PHASE_LOCKED_LOOP_CTRL2 = 8'h0C;
    localparam logic [7:0] OFS_OSC_CTRL = 8'h10;
    localparam logic [7:0] OFS_CKO_CTRL = 8'h14;
    localparam logic [7:0] OFS_MOSC_WAIT = 8'h18;
    localparam logic [7:0] OFS_MOSC_DRIVE = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

    // PLL control: divider bits 1:0, multiplier bits 13:8
    localparam int PDIV_LO = 0;
    localparam int MUL_LO = 8;
    localparam logic [1:0] PDIV_1 = 2'h0;
    localparam logic [1:0] PDIV_2 = 2'h1;
    localparam logic [1:0] PDIV_4 = 2'h2;
    localparam logic [5:0] MUL_MIN = 6'h07;
    localparam logic [5:0] MUL_MAX = 6'h1E;
    localparam logic [31:0] PLL_CTRL_RST = 32'h0000_0700;

    // Oscillator control: stop bits, each 1 = stopped
    localparam int OSC_MAIN_STOP = 0;
    localparam int OSC_SUB_STOP = 1;
    localparam int OSC_HIGH_SPEED_ONCHIP_OSC_STOP = 2;
    localparam int OSC_SUB_EXT = 3;
    localparam int OSC_HIGH_SPEED_ONCHIP_OSC_FREQ_LO = 4;
    localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0007;
    localparam logic [1:0] HIGH_SPEED_ONCHIP_OSC_24 = 2'h0;
    localparam logic [1:0] HIGH_SPEED_ONCHIP_OSC_32 = 2'h1;
    localparam logic [1:0] HIGH_SPEED_ONCHIP_OSC_48 = 2'h2;
    localparam logic [1:0] HIGH_SPEED_ONCHIP_OSC_64 = 2'h3;

    // Clock output control
    localparam int CKO_SEL_LO = 8;
    localparam int CKO_DIV_LO = 12;
    localparam int CKO_STOP = 15;
    localparam logic [3:0] CKO_LOW_SPEED_ONCHIP_OSC = 4'h0;
    localparam logic [3:0] CKO_HIGH_SPEED_ONCHIP_OSC = 4'h1;
    localparam logic [3:0] CKO_MAIN = 4'h2;
    localparam logic [3:0] CKO_SUB = 4'h3;
    localparam logic [3:0] CKO_PLL = 4'h4;
    localparam logic [3:0] CKO_TOUCH = 4'h8;
    localparam logic [31:0] CKO_CTRL_RST = 32'h0000_8000;
    localparam int CKO_DIV_W = 8;

    // Main oscillator wait
    localparam logic [4:0] MSW_MAX = 5'h08;
    localparam logic [31:0] MOSC_WAIT_RST = 32'h0000_0000;
    localparam int WAIT_W = 18;
    localparam logic [WAIT_W-1:0] MSW_BASE = 18'h00400;

    // Status and event bits
    localparam int ST_MAIN = 0;
    localparam int ST_PLL = 1;
    localparam int ST_SECOND_PHASE_LOCKED_LOOP = 2;
    localparam int ST_MAIN_FAIL = 3;
    localparam int EV_W = 4;

    // PLL lock wait, counted in block clocks
    localparam int PLL_LOCK_US = 100;
    localparam int CLK_MHZ = 200;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    // Main clock stop detection: no main edge for this long
    localparam int MSTOP_NS = 1000;
    localparam int CLK_NS = 5;
    localparam int MSTOP_CYC = MSTOP_NS / CLK_NS;

    typedef enum logic [1:0] {
        SYS_LOW_SPEED_ONCHIP_OSC = 2'h0,
        SYS_MAIN = 2'h1
    } csp_sys_t;

    typedef struct packed {
        logic [5:0] mul;
        logic [1:0] div;
        logic run;
    } csp_pll_cfg_t;
endpackage

// ---- rtl/csp_pll_ctl.sv ----
/*
 * One PLL's sequencer: registered settings, enable, and lock wait.
 * Assumes the analog loop follows pll_cfg and needs PLL_LOCK_CYC to settle.
 */
`timescale 1ns/1ps
module csp_pll_ctl #(
    parameter int LOCK_CYC = csp_pkg::PLL_LOCK_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic wr_ctrl,
    input wire logic wr_run,
    input wire logic [31:0] wdata,
    input wire logic main_ok,
    output csp_pkg::csp_pll_cfg_t pll_cfg,
    output logic stable
);
    logic [15:0] cnt;
    logic [5:0] wr_mul;
    logic mul_ok;

    assign wr_mul = wdata[csp_pkg::MUL_LO +: 6];
    assign mul_ok = wr_mul >= csp_pkg::MUL_MIN && wr_mul <= csp_pkg::MUL_MAX;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_cfg <= '{mul: csp_pkg::MUL_MIN, div: csp_pkg::PDIV_1, run: 1'b0};
            cnt <= 16'h0000;
            stable <= 1'b0;
        end else if (ce) begin
            // Settings frozen while running; bad codes ignored
            if (wr_ctrl && !pll_cfg.run) begin
                if (mul_ok) begin
                    pll_cfg.mul <= wr_mul;
                end
                if (wdata[csp_pkg::PDIV_LO +: 2] != 2'h3) begin
                    pll_cfg.div <= wdata[csp_pkg::PDIV_LO +: 2];
                end
            end
            if (wr_run) begin
                pll_cfg.run <= wdata[0] & main_ok;
            end
            if (!pll_cfg.run || !main_ok) begin
                cnt <= 16'h0000;
                stable <= 1'b0;
            end else if (cnt == 16'(LOCK_CYC - 1)) begin
                stable <= 1'b1;
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
endmodule

// ---- rtl/csp_top.sv ----
/*
 * Clock source and PLL configuration block with AHB-Lite registers.
 * Assumes oscillator outputs arrive as asynchronous pins and are
 * synchronised here; frequency-derived outputs are control levels.
 */
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module csp_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic low_speed_onchip_osc_clk,
    input wire logic main_clk,
    input wire logic sub_xtal_clk,
    input wire logic subclock_external_input,
    input wire logic high_speed_onchip_osc_clk,
    input wire logic touch_obs_clk,
    input wire logic pll_clk,
    output csp_pkg::csp_pll_cfg_t pll_cfg,
    output csp_pkg::csp_pll_cfg_t second_pll_cfg,
    output logic [1:0] high_speed_onchip_osc_freq_sel,
    output logic high_speed_onchip_osc_run,
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic sub_from_external,
    output logic main_osc_drive_select,
    output logic [31:0] low_speed_onchip_osc_freq_hz,
    output logic [31:0] wdt_osc_freq_hz,
    output csp_pkg::csp_sys_t sys_clk_src,
    output logic timer_pin_hiz,
    output logic clock_output_pin,
    output logic irq
);
    localparam logic [31:0] LOW_SPEED_ONCHIP_OSC_HZ = 32'd4000000;
    localparam logic [31:0] WDT_HZ = 32'd15000;

    // AHB address phase capture
    logic dp_wr;
    logic dp_rd;
    logic [7:0] dp_addr;
    logic ap_valid;
    assign ap_valid = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 8'h00;
        end else if (ce) begin
            dp_wr <= ap_valid && hwrite;
            dp_rd <= ap_valid && !hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic wr_pll;
    logic wr_second_phase_locked_loop;
    logic wr_pll_run;
    logic wr_second_phase_locked_loop_run;
    logic wr_osc;
    logic wr_cko;
    logic wr_msw;
    logic wr_drv;
    logic wr_ist;
    logic wr_imsk;
    assign wr_pll = dp_wr && hit(dp_addr, csp_pkg::OFS_PLL_CTRL);
    assign wr_pll_run = dp_wr && hit(dp_addr, csp_pkg::OFS_PLL_CTRL2);
    assign wr_second_phase_locked_loop = dp_wr && hit(dp_addr, csp_pkg::OFS_SECOND_PHASE_LOCKED_LOOP_CTRL);
    assign wr_second_phase_locked_loop_run = dp_wr && hit(dp_addr, csp_pkg::OFS_SECOND_PHASE_LOCKED_LOOP_CTRL2);
    assign wr_osc = dp_wr && hit(dp_addr, csp_pkg::OFS_OSC_CTRL);
    assign wr_cko = dp_wr && hit(dp_addr, csp_pkg::OFS_CKO_CTRL);
    assign wr_msw = dp_wr && hit(dp_addr, csp_pkg::OFS_MOSC_WAIT);
    assign wr_drv = dp_wr && hit(dp_addr, csp_pkg::OFS_MOSC_DRIVE);
    assign wr_ist = dp_wr && hit(dp_addr, csp_pkg::OFS_IRQ_STAT);
    assign wr_imsk = dp_wr && hit(dp_addr, csp_pkg::OFS_IRQ_MASK);

    // Pin synchronisers
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_s3;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
            pin_s3 <= 6'h00;
        end else if (ce) begin
            pin_s1 <= {pll_clk, touch_obs_clk, high_speed_onchip_osc_clk, main_clk, low_speed_onchip_osc_clk,
                subclock_external_input};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    logic [5:0] pin_rise;
    assign pin_rise = pin_s2 & ~pin_s3;
    logic sub_s;
    logic [1:0] sub_sync;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_sync <= 2'h0;
        end else if (ce) begin
            sub_sync <= {sub_sync[0], sub_xtal_clk};
        end
    end

    // Configuration registers
    logic [31:0] osc_ctrl;
    logic [3:0] cko_sel;
    logic [2:0] cko_div;
    logic cko_stop;
    logic [4:0] msw_code;
    logic [csp_pkg::EV_W-1:0] irq_stat;
    logic [csp_pkg::EV_W-1:0] irq_mask;
    logic [3:0] w_sel;
    logic w_sel_ok;
    assign w_sel = hwdata[csp_pkg::CKO_SEL_LO +: 4];
    assign w_sel_ok = w_sel <= csp_pkg::CKO_PLL || w_sel == csp_pkg::CKO_TOUCH;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_ctrl <= csp_pkg::OSC_CTRL_RST;
            cko_sel <= csp_pkg::CKO_LOW_SPEED_ONCHIP_OSC;
            cko_div <= 3'h0;
            cko_stop <= 1'b1;
            msw_code <= 5'h00;
            main_osc_drive_select <= 1'b0;
            irq_mask <= '0;
        end else if (ce) begin
            if (wr_osc) begin
                osc_ctrl <= {26'h0, hwdata[5:0]};
            end
            if (wr_cko) begin
                if (w_sel_ok) begin
                    cko_sel <= w_sel;
                end
                cko_div <= hwdata[csp_pkg::CKO_DIV_LO +: 3];
                cko_stop <= hwdata[csp_pkg::CKO_STOP];
            end
            if (wr_msw && hwdata[4:0] <= csp_pkg::MSW_MAX) begin
                msw_code <= hwdata[4:0];
            end
            if (wr_drv) begin
                main_osc_drive_select <= hwdata[0];
            end
            if (wr_imsk) begin
                irq_mask <= hwdata[csp_pkg::EV_W-1:0];
            end
        end
    end

    assign main_osc_run = !osc_ctrl[csp_pkg::OSC_MAIN_STOP];
    assign sub_osc_run = !osc_ctrl[csp_pkg::OSC_SUB_STOP];
    assign high_speed_onchip_osc_run = !osc_ctrl[csp_pkg::OSC_HIGH_SPEED_ONCHIP_OSC_STOP];
    assign sub_from_external = osc_ctrl[csp_pkg::OSC_SUB_EXT];
    assign high_speed_onchip_osc_freq_sel = osc_ctrl[csp_pkg::OSC_HIGH_SPEED_ONCHIP_OSC_FREQ_LO +: 2];
    assign low_speed_onchip_osc_freq_hz = LOW_SPEED_ONCHIP_OSC_HZ;
    assign wdt_osc_freq_hz = WDT_HZ;
    assign sub_s = sub_from_external ? pin_s2[0] : sub_sync[1];

    // Main oscillator wait counted on slow oscillator edges
    logic [csp_pkg::WAIT_W-1:0] msw_cnt;
    logic [csp_pkg::WAIT_W-1:0] msw_target;
    logic main_ok;
    logic mstop;
    assign msw_target = (msw_code == 5'h00) ? '0 :
        csp_pkg::WAIT_W'(csp_pkg::MSW_BASE << (msw_code - 5'h01));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msw_cnt <= '0;
            main_ok <= 1'b0;
        end else if (ce) begin
            if (!main_osc_run || mstop) begin
                msw_cnt <= '0;
                main_ok <= 1'b0;
            end else if (msw_cnt >= msw_target) begin
                main_ok <= 1'b1;
            end else if (pin_rise[1]) begin
                msw_cnt <= msw_cnt + 1'b1;
            end
        end
    end

    // Main clock stop detection
    logic [7:0] mstop_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mstop_cnt <= 8'h00;
            mstop <= 1'b0;
        end else if (ce) begin
            if (!main_osc_run || pin_rise[2]) begin
                mstop_cnt <= 8'h00;
                mstop <= 1'b0;
            end else if (mstop_cnt == 8'(csp_pkg::MSTOP_CYC - 1)) begin
                mstop <= main_ok | mstop;
            end else begin
                mstop_cnt <= mstop_cnt + 8'h01;
            end
        end
    end
    assign sys_clk_src = mstop ? csp_pkg::SYS_LOW_SPEED_ONCHIP_OSC : csp_pkg::SYS_MAIN;
    assign timer_pin_hiz = mstop;

    // Both PLLs, same sequencer
    logic pll_stable;
    logic second_phase_locked_loop_stable;
    csp_pll_ctl u_pll (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .wr_ctrl(wr_pll),
        .wr_run(wr_pll_run),
        .wdata(hwdata),
        .main_ok(main_ok),
        .pll_cfg(pll_cfg),
        .stable(pll_stable)
    );
    csp_pll_ctl u_second_phase_locked_loop (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .wr_ctrl(wr_second_phase_locked_loop),
        .wr_run(wr_second_phase_locked_loop_run),
        .wdata(hwdata),
        .main_ok(main_ok),
        .pll_cfg(second_pll_cfg),
        .stable(second_phase_locked_loop_stable)
    );

    // Clock output source and divider
    logic src_rise;
    logic sub_prev;
    logic [csp_pkg::CKO_DIV_W-1:0] cko_cnt;
    logic [csp_pkg::CKO_DIV_W-1:0] cko_half;
    always_comb begin
        unique case (cko_sel)
            csp_pkg::CKO_LOW_SPEED_ONCHIP_OSC: src_rise = pin_rise[1];
            csp_pkg::CKO_HIGH_SPEED_ONCHIP_OSC: src_rise = pin_rise[3];
            csp_pkg::CKO_MAIN: src_rise = pin_rise[2];
            csp_pkg::CKO_SUB: src_rise = sub_s & ~sub_prev;
            csp_pkg::CKO_PLL: src_rise = pin_rise[5];
            csp_pkg::CKO_TOUCH: src_rise = pin_rise[4];
            default: src_rise = 1'b0;
        endcase
    end
    assign cko_half = (cko_div == 3'h0) ? '0 :
        csp_pkg::CKO_DIV_W'((9'h001 << cko_div) >> 1) - 1'b1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_prev <= 1'b0;
            cko_cnt <= '0;
            clock_output_pin <= 1'b0;
        end else if (ce) begin
            sub_prev <= sub_s;
            if (cko_stop) begin
                cko_cnt <= '0;
                clock_output_pin <= 1'b0;
            end else if (src_rise) begin
                if (cko_cnt >= cko_half) begin
                    cko_cnt <= '0;
                    clock_output_pin <= ~clock_output_pin;
                end else begin
                    cko_cnt <= cko_cnt + 1'b1;
                end
            end
        end
    end

    // Interrupt events: set wins over write-one-clear
    logic [csp_pkg::EV_W-1:0] st_now;
    logic [csp_pkg::EV_W-1:0] st_prev;
    logic [csp_pkg::EV_W-1:0] ev;
    assign st_now = {mstop, second_phase_locked_loop_stable, pll_stable, main_ok};
    assign ev = st_now & ~st_prev;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_prev <= '0;
            irq_stat <= '0;
        end else if (ce) begin
            st_prev <= st_now;
            irq_stat <= (irq_stat & ~(wr_ist ? hwdata[csp_pkg::EV_W-1:0] : '0)) | ev;
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // Read data
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (dp_addr)
            csp_pkg::OFS_PLL_CTRL: rd_mux = {18'h0, pll_cfg.mul, 6'h0, pll_cfg.div};
            csp_pkg::OFS_PLL_CTRL2: rd_mux = {31'h0, pll_cfg.run};
            csp_pkg::OFS_SECOND_PHASE_LOCKED_LOOP_CTRL: rd_mux = {18'h0, second_pll_cfg.mul, 6'h0,
                second_pll_cfg.div};
            csp_pkg::OFS_SECOND_PHASE_LOCKED_LOOP_CTRL2: rd_mux = {31'h0, second_pll_cfg.run};
            csp_pkg::OFS_OSC_CTRL: rd_mux = osc_ctrl;
            csp_pkg::OFS_CKO_CTRL: rd_mux = {16'h0, cko_stop, cko_div, cko_sel, 8'h0};
            csp_pkg::OFS_MOSC_WAIT: rd_mux = {27'h0, msw_code};
            csp_pkg::OFS_MOSC_DRIVE: rd_mux = {31'h0, main_osc_drive_select};
            csp_pkg::OFS_STATUS: rd_mux = {28'h0, st_now};
            csp_pkg::OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat};
            csp_pkg::OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign hrdata = dp_rd ? rd_mux : 32'h0000_0000;
endmodule

// ---- testbench/csp_props.sv ----
/*
 * Port relations checked on the clock source block.
 * Bound to csp_top from tb_top; sees only the top ports.
 */
`timescale 1ns/1ps
module csp_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire csp_pkg::csp_pll_cfg_t pll_cfg,
    input wire csp_pkg::csp_pll_cfg_t second_pll_cfg,
    input wire logic main_osc_run,
    input wire logic [31:0] low_speed_onchip_osc_freq_hz,
    input wire logic [31:0] wdt_osc_freq_hz,
    input wire csp_pkg::csp_sys_t sys_clk_src,
    input wire logic timer_pin_hiz,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_LOW_SPEED_ONCHIP_OSC_FIXED: assert property (low_speed_onchip_osc_freq_hz == 32'h003D_0900)
        else $error("slow oscillator rate wrong");
    AST_WDT_FIXED: assert property (wdt_osc_freq_hz == 32'h0000_3A98)
        else $error("watchdog oscillator rate wrong");
    AST_PLL_MUL_RANGE: assert property (
        pll_cfg.mul inside {[csp_pkg::MUL_MIN:csp_pkg::MUL_MAX]})
        else $error("multiplier code out of range");
    AST_PLL_DIV_LEGAL: assert property (pll_cfg.div != 2'h3)
        else $error("pre-divider code illegal");
    AST_SECOND_PHASE_LOCKED_LOOP_CODES: assert property (second_pll_cfg.div != 2'h3 &&
        second_pll_cfg.mul inside {[csp_pkg::MUL_MIN:csp_pkg::MUL_MAX]})
        else $error("second loop code illegal");
    AST_PLL_HOLD: assert property (pll_cfg.run && $past(pll_cfg.run) |->
        $stable({pll_cfg.mul, pll_cfg.div}))
        else $error("loop settings changed while running");
    AST_PLL_NEEDS_MAIN: assert property ($rose(pll_cfg.run) |-> main_osc_run)
        else $error("loop started without main clock");
    AST_SECOND_PHASE_LOCKED_LOOP_NEEDS_MAIN: assert property ($rose(second_pll_cfg.run) |-> main_osc_run)
        else $error("second loop started without main clock");
    AST_HIZ_WITH_LOW_SPEED_ONCHIP_OSC: assert property (
        timer_pin_hiz == (sys_clk_src == csp_pkg::SYS_LOW_SPEED_ONCHIP_OSC))
        else $error("float and clock switch disagree");
    AST_HIZ_NEEDS_MAIN: assert property ($rose(timer_pin_hiz) |-> $past(main_osc_run))
        else $error("stop detected with main clock off");
    COV_PLL_RUN: cover property ($rose(pll_cfg.run));
    COV_SECOND_PHASE_LOCKED_LOOP_RUN: cover property ($rose(second_pll_cfg.run));
    COV_MAIN_STOP: cover property ($rose(timer_pin_hiz));
    COV_IRQ: cover property ($rose(irq));
endmodule

// ---- testbench/csp_osc_model.sv ----
/*
 * Oscillator sources facing the clock source block.
 * Rates are scaled up; all stay slower than half of hclk.
 */
`timescale 1ns/1ps
module csp_osc_model (
    input wire logic main_run,
    input wire logic main_ok,
    output logic low_speed_onchip_osc_clk,
    output logic main_clk,
    output logic sub_xtal_clk,
    output logic sub_ext_clk,
    output logic high_speed_onchip_osc_clk,
    output logic touch_clk,
    output logic pll_clk
);
    initial {low_speed_onchip_osc_clk, main_clk, sub_xtal_clk, sub_ext_clk} = 4'h0;
    initial {high_speed_onchip_osc_clk, touch_clk, pll_clk} = 3'h0;
    always #20 low_speed_onchip_osc_clk = ~low_speed_onchip_osc_clk;
    // Crystal only swings while enabled and not broken
    always #15 if (main_run && main_ok) main_clk = ~main_clk;
    always #25 sub_xtal_clk = ~sub_xtal_clk;
    always #35 sub_ext_clk = ~sub_ext_clk;
    always #10 high_speed_onchip_osc_clk = ~high_speed_onchip_osc_clk;
    always #30 touch_clk = ~touch_clk;
    always #11 pll_clk = ~pll_clk;
endmodule

// ---- testbench/tb_top.sv ----
/*
 * Self-checking bench for the clock source block.
 * Drives AHB-Lite single words; oscillators come from csp_osc_model.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", n, (e), (g)); end end
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic main_ok = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, low_speed_onchip_osc_freq_hz, wdt_osc_freq_hz;
    logic hreadyout, hresp, high_speed_onchip_osc_run, main_osc_run, sub_osc_run, sub_from_external;
    logic main_osc_drive_select, timer_pin_hiz, clock_output_pin, irq;
    logic low_speed_onchip_osc_clk, main_clk, sub_xtal_clk, sub_ext_clk, high_speed_onchip_osc_clk, touch_clk, pll_clk;
    logic [1:0] high_speed_onchip_osc_freq_sel;
    csp_pkg::csp_pll_cfg_t pll_cfg, second_pll_cfg;
    csp_pkg::csp_sys_t sys_clk_src;
    int fails = 0;
    int cmp_count = 0;
    always #2.5 hclk = ~hclk;
    csp_top dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .low_speed_onchip_osc_clk, .main_clk, .sub_xtal_clk, .subclock_external_input(sub_ext_clk),
        .high_speed_onchip_osc_clk, .touch_obs_clk(touch_clk), .pll_clk, .pll_cfg, .second_pll_cfg,
        .high_speed_onchip_osc_freq_sel, .high_speed_onchip_osc_run, .main_osc_run, .sub_osc_run, .sub_from_external,
        .main_osc_drive_select, .low_speed_onchip_osc_freq_hz, .wdt_osc_freq_hz, .sys_clk_src,
        .timer_pin_hiz, .clock_output_pin, .irq);
    csp_osc_model osc (.main_run(main_osc_run), .main_ok, .low_speed_onchip_osc_clk, .main_clk,
        .sub_xtal_clk, .sub_ext_clk, .high_speed_onchip_osc_clk, .touch_clk, .pll_clk);
    task stop_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        #1;
    endtask
    task chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %0h", a), e & m, rd & m)
        `CHK("resp", 1'b0, hresp)
    endtask
    task t_reset;
        chk(csp_pkg::OFS_PLL_CTRL, 32'hFFFFFFFF, csp_pkg::PLL_CTRL_RST);
        chk(csp_pkg::OFS_OSC_CTRL, 32'hFFFFFFFF, csp_pkg::OSC_CTRL_RST);
        chk(csp_pkg::OFS_CKO_CTRL, 32'hFFFFFFFF, csp_pkg::CKO_CTRL_RST);
        chk(csp_pkg::OFS_MOSC_WAIT, 32'hFFFFFFFF, csp_pkg::MOSC_WAIT_RST);
        chk(csp_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'h0);
        wr(8'h40, 32'hFFFFFFFF);
        chk(8'h40, 32'hFFFFFFFF, 32'h0);
        wr(csp_pkg::OFS_SECOND_PHASE_LOCKED_LOOP_CTRL2, 32'h1);
        `CHK("loop2 run", 1'b0, second_pll_cfg.run)
        `CHK("cko pin", 1'b0, clock_output_pin)
        `CHK("low_speed_onchip_osc hz", 32'h003D0900, low_speed_onchip_osc_freq_hz)
        `CHK("wdt hz", 32'h00003A98, wdt_osc_freq_hz)
    endtask
    task t_pll(input logic [7:0] base, input logic sec);
        logic [5:0] m;
        logic [1:0] d;
        logic ok;
        csp_pkg::csp_pll_cfg_t cfg;
        m = 6'h07;
        d = 2'h0;
        chk(base, 32'hFFFFFFFF, csp_pkg::PLL_CTRL_RST);
        for (int c = 0; c < 64; c++) begin
            ok = c >= 7 && c <= 30;
            if (ok) d = 2'(c % 3);
            wr(base, {18'h0, c[5:0], 6'h0, d});
            if (ok) m = c[5:0];
            chk(base, 32'h3F03, {18'h0, m, 6'h0, d});
            cfg = sec ? second_pll_cfg : pll_cfg;
            `CHK("loop mul", m, cfg.mul)
        end
        wr(base, {18'h0, m, 8'h03});
        chk(base, 32'h3F03, {18'h0, m, 6'h0, d});
    endtask
    task t_osc;
        for (int f = 0; f < 4; f++) begin
            wr(csp_pkg::OFS_OSC_CTRL, {26'h0, f[1:0], f[0], 3'b011});
            chk(csp_pkg::OFS_OSC_CTRL, 32'h3F, {26'h0, f[1:0], f[0], 3'b011});
            `CHK("high_speed_onchip_osc sel", f[1:0], high_speed_onchip_osc_freq_sel)
            `CHK("high_speed_onchip_osc run", 1'b1, high_speed_onchip_osc_run)
            `CHK("sub ext", f[0], sub_from_external)
            `CHK("sub run", 1'b0, sub_osc_run)
            `CHK("main run", 1'b0, main_osc_run)
        end
        for (int b = 0; b < 2; b++) begin
            wr(csp_pkg::OFS_MOSC_DRIVE, {31'h0, b[0]});
            `CHK("drive", b[0], main_osc_drive_select)
        end
    endtask
    task count_cko(input logic [2:0] code, output int n);
        logic last;
        wr(csp_pkg::OFS_CKO_CTRL, {17'h0, code, 12'h0});
        repeat (64) @(posedge hclk);
        n = 0;
        last = clock_output_pin;
        repeat (1024) begin
            @(posedge hclk);
            if (clock_output_pin !== last) n++;
            last = clock_output_pin;
        end
    endtask
    task t_cko;
        logic [3:0] cur;
        int t1, t2;
        cur = 4'h0;
        for (int s = 0; s < 16; s++) begin
            wr(csp_pkg::OFS_CKO_CTRL, {16'h1, 4'h8, s[3:0], 8'h0});
            if (s inside {0, 1, 2, 3, 4, 8}) cur = s[3:0];
            chk(csp_pkg::OFS_CKO_CTRL, 32'h0F00, {20'h0, cur, 8'h0});
        end
        for (int d = 1; d < 8; d++) begin
            wr(csp_pkg::OFS_CKO_CTRL, {16'h0, 1'b1, d[2:0], 12'h0});
            chk(csp_pkg::OFS_CKO_CTRL, 32'h7000, {17'h0, d[2:0], 12'h0});
        end
        count_cko(3'h1, t1);
        count_cko(3'h2, t2);
        `CHK("cko ratio", 1'b1, t2 > 0 && 2 * t2 >= t1 - 4 && 2 * t2 <= t1 + 4)
        wr(csp_pkg::OFS_CKO_CTRL, csp_pkg::CKO_CTRL_RST);
    endtask
    task t_main_pll;
        wr(csp_pkg::OFS_MOSC_WAIT, 32'h9);
        chk(csp_pkg::OFS_MOSC_WAIT, 32'h1F, 32'h0);
        wr(csp_pkg::OFS_MOSC_WAIT, 32'h1);
        wr(csp_pkg::OFS_IRQ_MASK, 32'h1);
        wr(csp_pkg::OFS_OSC_CTRL, 32'h6);
        repeat (8000) @(posedge hclk);
        chk(csp_pkg::OFS_STATUS, 32'h1, 32'h0);
        `CHK("irq early", 1'b0, irq)
        repeat (300) @(posedge hclk);
        chk(csp_pkg::OFS_STATUS, 32'h1, 32'h1);
        `CHK("irq set", 1'b1, irq)
        wr(csp_pkg::OFS_IRQ_STAT, 32'h1);
        `CHK("irq clear", 1'b0, irq)
        wr(csp_pkg::OFS_PLL_CTRL2, 32'h1);
        wr(csp_pkg::OFS_SECOND_PHASE_LOCKED_LOOP_CTRL2, 32'h1);
        `CHK("loop run", 1'b1, pll_cfg.run)
        `CHK("loop2 run", 1'b1, second_pll_cfg.run)
        wr(csp_pkg::OFS_PLL_CTRL, 32'h0701);
        chk(csp_pkg::OFS_PLL_CTRL, 32'h3F03, 32'h1E00);
        repeat (19800) @(posedge hclk);
        chk(csp_pkg::OFS_STATUS, 32'h6, 32'h0);
        repeat (300) @(posedge hclk);
        chk(csp_pkg::OFS_STATUS, 32'h6, 32'h6);
        `CHK("irq masked", 1'b0, irq)
        chk(csp_pkg::OFS_IRQ_STAT, 32'h6, 32'h6);
        wr(csp_pkg::OFS_PLL_CTRL2, 32'h0);
        chk(csp_pkg::OFS_STATUS, 32'h2, 32'h0);
    endtask
    task t_main_stop;
        @(posedge hclk);
        main_ok <= 1'b0;
        repeat (180) @(posedge hclk);
        `CHK("hiz early", 1'b0, timer_pin_hiz)
        repeat (60) @(posedge hclk);
        `CHK("hiz", 1'b1, timer_pin_hiz)
        `CHK("sys src", csp_pkg::SYS_LOW_SPEED_ONCHIP_OSC, sys_clk_src)
        chk(csp_pkg::OFS_STATUS, 32'h8, 32'h8);
        main_ok <= 1'b1;
        repeat (40) @(posedge hclk);
        `CHK("hiz off", 1'b0, timer_pin_hiz)
        `CHK("sys back", csp_pkg::SYS_MAIN, sys_clk_src)
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_pll(csp_pkg::OFS_PLL_CTRL, 1'b0);
        t_pll(csp_pkg::OFS_SECOND_PHASE_LOCKED_LOOP_CTRL, 1'b1);
        t_osc;
        t_cko;
        t_main_pll;
        t_main_stop;
        stop_test;
    end
    initial begin
        repeat (60000) @(posedge hclk);
        fails++;
        stop_test;
    end
endmodule
bind csp_top csp_props u_props (.hclk, .hresetn, .pll_cfg, .second_pll_cfg, .main_osc_run,
    .low_speed_onchip_osc_freq_hz, .wdt_osc_freq_hz, .sys_clk_src, .timer_pin_hiz, .irq);
